/* include/pifb_consts.svh */
`ifndef PIFB_CONSTS_SVH
`define PIFB_CONSTS_SVH

// ==========================================================
// Bus geometry
`define PIFB_ADDR_W        5
`define PIFB_DATA_W        32
`define PIFB_BE_W          4
`define PIFB_GRP_W         4

// ==========================================================
// Register byte offsets
`define PIFB_OFS_SER2_EN   5'h00
`define PIFB_OFS_FLAGS_A   5'h04
`define PIFB_OFS_FLAGS_B   5'h08
`define PIFB_OFS_FLAGS_C   5'h0c
`define PIFB_OFS_FLAGS_D   5'h10
`define PIFB_OFS_STATUS    5'h14
`define PIFB_OFS_MASK      5'h18

// ==========================================================
// Field positions
`define PIFB_BIT_TIMER1_GATE    7
`define PIFB_BIT_UART1_RX       5
`define PIFB_BIT_UART1_TX       4
`define PIFB_BIT_OSC_FAIL       7
`define PIFB_BIT_B_UNUSED       1
`define PIFB_BIT_CAPTURE5       6
`define PIFB_BIT_TIMER4_MATCH   1
`define PIFB_BIT_UART2_RX       5
`define PIFB_BIT_UART2_TX       4
`define PIFB_BIT_SYNC2_COLL     1
`define PIFB_BIT_SYNC2_EVENT    0

// ==========================================================
// Implemented and writable masks
`define PIFB_IMPL_EN       8'h33
`define PIFB_IMPL_A        8'hff
`define PIFB_WR_A          8'hcf
`define PIFB_IMPL_B        8'hfd
`define PIFB_WR_B          8'hfd
`define PIFB_IMPL_C        8'h7a
`define PIFB_WR_C          8'h7a
`define PIFB_IMPL_D        8'h33
`define PIFB_WR_D          8'h33

// ==========================================================
// Reset values
`define PIFB_RST_BYTE      8'h00
`define PIFB_RST_GRP       4'h0
`define PIFB_RST_WORD      32'h0000_0000

`endif

/* include/pifb_pkg.sv */
`include "pifb_consts.svh"

package pifb_pkg;

  // ==========================================================
  // Avalon-MM request and answer
  typedef struct packed {
    logic                     read;
    logic                     write;
    logic [`PIFB_ADDR_W-1:0]  address;
    logic [`PIFB_DATA_W-1:0]  writedata;
    logic [`PIFB_BE_W-1:0]    byteenable;
  } pifb_avmm_req_t;

  typedef struct packed {
    logic [`PIFB_DATA_W-1:0]  readdata;
    logic                     waitrequest;
  } pifb_avmm_rsp_t;

  // ==========================================================
  // One byte per flag register
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } pifb_bank_t;

  // Enables held outside this block
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
  } pifb_enables_t;

endpackage

/* core/pifb_flag_reg.sv */
`timescale 1ns/1ps
`include "pifb_consts.svh"

module pifb_flag_reg #(
  parameter logic [7:0] IMPL   = 8'hff,
  parameter logic [7:0] WRMASK = 8'hff
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [7:0] evt,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  output      logic [7:0] flags
);

  // ==========================================================
  // Flag state
  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  always_comb begin
    // Writable bits take write data, events win; read-only bits follow source
    flags_next = (((wr_stb ? wr_data : flags_reg) & WRMASK) | evt) & IMPL;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_reg <= `PIFB_RST_BYTE;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign flags = flags_reg;

endmodule

/* core/pifb_event_status.sv */
`timescale 1ns/1ps
`include "pifb_consts.svh"

module pifb_event_status (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [`PIFB_GRP_W-1:0] set_bits,
  input  wire logic                   rd_clr_stb,
  input  wire logic [`PIFB_GRP_W-1:0] clr_bits,
  input  wire logic                   mask_wr,
  input  wire logic [`PIFB_GRP_W-1:0] mask_data,
  output      logic [`PIFB_GRP_W-1:0] status,
  output      logic [`PIFB_GRP_W-1:0] mask,
  output      logic                   irq
);

  // ==========================================================
  // Sticky status, mask and interrupt line
  logic [`PIFB_GRP_W-1:0] status_reg;
  logic [`PIFB_GRP_W-1:0] status_next;
  logic [`PIFB_GRP_W-1:0] mask_reg;
  logic [`PIFB_GRP_W-1:0] mask_next;
  logic                   irq_reg;
  logic                   irq_next;

  always_comb begin
    // Clear only what was read out; a new event wins
    status_next = (status_reg & ~(rd_clr_stb ? clr_bits : `PIFB_RST_GRP)) | set_bits;
    mask_next   = mask_wr ? mask_data : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      status_reg <= `PIFB_RST_GRP;
      mask_reg   <= `PIFB_RST_GRP;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = irq_reg;

endmodule

/* core/pifb_irq_bank.sv */
`timescale 1ns/1ps
`include "pifb_consts.svh"

// Operation
// - A flag sets on its source event regardless of any enable.
// - Serial-2 enable bits 5,4,1,0 for uart2 rx, tx, collision, event.
// - Serial-2 enable bits 7-6 and 3-2 always read zero.
// - All implemented enables and flags reset to zero.
// - Flags A hold timer1 gate down to timer1 overflow, bits 7 to 0.
// - Uart1 rx and tx flags are read-only; other A flags read/write.
// - Flags B hold osc fail down to capture2; bit 1 reads zero.
// - Flags C hold capture5,4,3, timer6 and timer4; bits 7,2,0 read zero.
// - A source requests service only while flag and enable are both one.
// - Flags D mirror serial-2 enable positions 5,4,1,0.

module pifb_irq_bank (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire pifb_pkg::pifb_avmm_req_t bus_req,
  output      pifb_pkg::pifb_avmm_rsp_t bus_rsp,
  input  wire pifb_pkg::pifb_bank_t     src,
  input  wire pifb_pkg::pifb_enables_t  en_ext,
  output      pifb_pkg::pifb_bank_t     req,
  output      logic                    service_req,
  output      logic                    irq
);

  // ==========================================================
  // Bus decode
  logic       wr_acc;
  logic       rd_acc;
  logic [7:0] wr_byte;

  assign wr_acc  = bus_req.write & ~bus_rsp.waitrequest & bus_req.byteenable[0];
  assign rd_acc  = bus_req.read & ~bus_rsp.waitrequest;
  assign wr_byte = bus_req.writedata[7:0];

  function automatic logic hit(input logic [`PIFB_ADDR_W-1:0] ofs);
    hit = wr_acc && (bus_req.address == ofs);
  endfunction

  // Write strobes for flags a to d and the mask; the serial-2 enable write uses hit() directly
  logic wr_hit_a;
  logic wr_hit_b;
  logic wr_hit_c;
  logic wr_hit_d;
  logic wr_hit_mask;

  always_comb begin
    wr_hit_a    = hit(`PIFB_OFS_FLAGS_A);
    wr_hit_b    = hit(`PIFB_OFS_FLAGS_B);
    wr_hit_c    = hit(`PIFB_OFS_FLAGS_C);
    wr_hit_d    = hit(`PIFB_OFS_FLAGS_D);
    wr_hit_mask = hit(`PIFB_OFS_MASK);
  end

  // ==========================================================
  // Flag registers
  logic [7:0] flags_a;
  logic [7:0] flags_b;
  logic [7:0] flags_c;
  logic [7:0] flags_d;

  pifb_flag_reg #(
    .IMPL   (`PIFB_IMPL_A),
    .WRMASK (`PIFB_WR_A)
  ) u_flags_a (
    .mclk    (mclk),
    .rst     (rst),
    .evt     (src.a),
    .wr_stb  (wr_hit_a),
    .wr_data (wr_byte),
    .flags   (flags_a)
  );

  pifb_flag_reg #(
    .IMPL   (`PIFB_IMPL_B),
    .WRMASK (`PIFB_WR_B)
  ) u_flags_b (
    .mclk    (mclk),
    .rst     (rst),
    .evt     (src.b),
    .wr_stb  (wr_hit_b),
    .wr_data (wr_byte),
    .flags   (flags_b)
  );

  pifb_flag_reg #(
    .IMPL   (`PIFB_IMPL_C),
    .WRMASK (`PIFB_WR_C)
  ) u_flags_c (
    .mclk    (mclk),
    .rst     (rst),
    .evt     (src.c),
    .wr_stb  (wr_hit_c),
    .wr_data (wr_byte),
    .flags   (flags_c)
  );

  pifb_flag_reg #(
    .IMPL   (`PIFB_IMPL_D),
    .WRMASK (`PIFB_WR_D)
  ) u_flags_d (
    .mclk    (mclk),
    .rst     (rst),
    .evt     (src.d),
    .wr_stb  (wr_hit_d),
    .wr_data (wr_byte),
    .flags   (flags_d)
  );

  // ==========================================================
  // Serial-2 enable register
  logic [7:0] ser2_en_reg;
  logic [7:0] ser2_en_next;

  always_comb begin
    ser2_en_next = ser2_en_reg;
    if (hit(`PIFB_OFS_SER2_EN)) begin
      ser2_en_next = wr_byte & `PIFB_IMPL_EN;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      ser2_en_reg <= `PIFB_RST_BYTE;
    end else begin
      ser2_en_reg <= ser2_en_next;
    end
  end

  // ==========================================================
  // Event summary and interrupt
  logic [`PIFB_GRP_W-1:0] grp_set;
  logic [`PIFB_GRP_W-1:0] status;
  logic [`PIFB_GRP_W-1:0] mask;
  logic                   status_rd;

  assign grp_set[0] = |(src.a & ~flags_a & `PIFB_IMPL_A);
  assign grp_set[1] = |(src.b & ~flags_b & `PIFB_IMPL_B);
  assign grp_set[2] = |(src.c & ~flags_c & `PIFB_IMPL_C);
  assign grp_set[3] = |(src.d & ~flags_d & `PIFB_IMPL_D);
  assign status_rd  = rd_acc && (bus_req.address == `PIFB_OFS_STATUS);

  pifb_event_status u_status (
    .mclk       (mclk),
    .rst        (rst),
    .set_bits   (grp_set),
    .rd_clr_stb (status_rd),
    .clr_bits   (bus_rsp.readdata[`PIFB_GRP_W-1:0]),
    .mask_wr    (wr_hit_mask),
    .mask_data  (wr_byte[`PIFB_GRP_W-1:0]),
    .status     (status),
    .mask       (mask),
    .irq        (irq)
  );

  // ==========================================================
  // Bus answer
  pifb_pkg::pifb_avmm_rsp_t rsp_reg;
  pifb_pkg::pifb_avmm_rsp_t rsp_next;

  always_comb begin
    rsp_next             = rsp_reg;
    rsp_next.waitrequest = 1'b1;
    if ((bus_req.read | bus_req.write) && rsp_reg.waitrequest) begin
      rsp_next.waitrequest = 1'b0;
      rsp_next.readdata    = `PIFB_RST_WORD;
      if (bus_req.read) begin
        case (bus_req.address)
          `PIFB_OFS_SER2_EN: rsp_next.readdata[7:0] = ser2_en_reg;
          `PIFB_OFS_FLAGS_A: rsp_next.readdata[7:0] = flags_a;
          `PIFB_OFS_FLAGS_B: rsp_next.readdata[7:0] = flags_b;
          `PIFB_OFS_FLAGS_C: rsp_next.readdata[7:0] = flags_c;
          `PIFB_OFS_FLAGS_D: rsp_next.readdata[7:0] = flags_d;
          `PIFB_OFS_STATUS:  rsp_next.readdata[`PIFB_GRP_W-1:0] = status;
          `PIFB_OFS_MASK:    rsp_next.readdata[`PIFB_GRP_W-1:0] = mask;
          default:           rsp_next.readdata = `PIFB_RST_WORD;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp_reg <= '{readdata: `PIFB_RST_WORD, waitrequest: 1'b1};
    end else begin
      rsp_reg <= rsp_next;
    end
  end

  assign bus_rsp = rsp_reg;

  // ==========================================================
  // Service requests
  pifb_pkg::pifb_bank_t req_reg;
  pifb_pkg::pifb_bank_t req_next;
  logic                 service_reg;
  logic                 service_next;

  always_comb begin
    req_next.a   = flags_a & en_ext.a;
    req_next.b   = flags_b & en_ext.b & `PIFB_IMPL_B;
    req_next.c   = flags_c & en_ext.c & `PIFB_IMPL_C;
    req_next.d   = flags_d & ser2_en_reg;
    service_next = |req_next;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      req_reg     <= '0;
      service_reg <= 1'b0;
    end else begin
      req_reg     <= req_next;
      service_reg <= service_next;
    end
  end

  assign req         = req_reg;
  assign service_req = service_reg;

  // ==========================================================
  // Checks
  a_event_sets_b:
  assert property (@(posedge mclk) disable iff (rst)
    (src.b & `PIFB_IMPL_B) != 8'h00 |=>
      ((flags_b & $past(src.b)) == ($past(src.b) & `PIFB_IMPL_B)))
    else $error("flag b event not captured");

  a_enable_write:
  assert property (@(posedge mclk) disable iff (rst)
    hit(`PIFB_OFS_SER2_EN) |=>
      ser2_en_reg == ($past(wr_byte) & `PIFB_IMPL_EN))
    else $error("serial-2 enable write lost");

  a_enable_unused_zero:
  assert property (@(posedge mclk) disable iff (rst)
    rsp_reg.waitrequest ##1 (!rsp_reg.waitrequest && $past(bus_req.read)
      && $past(bus_req.address) == `PIFB_OFS_SER2_EN) |->
      (rsp_reg.readdata & ~32'h0000_0033) == 32'h0000_0000)
    else $error("serial-2 enable unused bits not zero");

  a_reset_clears:
  assert property (@(posedge mclk)
    rst |=> (ser2_en_reg == 8'h00) && (flags_a == 8'h00) && (flags_b == 8'h00)
      && (flags_c == 8'h00) && (flags_d == 8'h00))
    else $error("reset left state");

  a_gate_position:
  assert property (@(posedge mclk) disable iff (rst)
    src.a[`PIFB_BIT_TIMER1_GATE] |=> flags_a[`PIFB_BIT_TIMER1_GATE])
    else $error("timer1 gate flag not at bit 7");

  a_uart1_read_only:
  assert property (@(posedge mclk) disable iff (rst)
    hit(`PIFB_OFS_FLAGS_A) |=>
      flags_a[`PIFB_BIT_UART1_RX:`PIFB_BIT_UART1_TX] ==
        $past(src.a[`PIFB_BIT_UART1_RX:`PIFB_BIT_UART1_TX]))
    else $error("uart1 flag changed by write");

  a_b_bit1_zero:
  assert property (@(posedge mclk) disable iff (rst)
    !flags_b[`PIFB_BIT_B_UNUSED] && !req.b[`PIFB_BIT_B_UNUSED])
    else $error("flags b bit 1 not zero");

  a_c_unused_zero:
  assert property (@(posedge mclk) disable iff (rst)
    (flags_c & ~`PIFB_IMPL_C) == 8'h00)
    else $error("flags c unused bits not zero");

  a_request_gate:
  assert property (@(posedge mclk) disable iff (rst)
    ##1 req.d == ($past(flags_d) & $past(ser2_en_reg)))
    else $error("serial-2 request not flag and enable");

  a_d_positions:
  assert property (@(posedge mclk) disable iff (rst)
    src.d[`PIFB_BIT_UART2_RX] ##1 ser2_en_reg[`PIFB_BIT_UART2_RX] |=>
      req.d[`PIFB_BIT_UART2_RX] && service_req)
    else $error("uart2 rx request missing");

  a_set_beats_clear:
  assert property (@(posedge mclk) disable iff (rst)
    hit(`PIFB_OFS_FLAGS_B) && !wr_byte[`PIFB_BIT_OSC_FAIL]
      && src.b[`PIFB_BIT_OSC_FAIL] |=> flags_b[`PIFB_BIT_OSC_FAIL])
    else $error("event lost to clear");

  a_write_zero_clears:
  assert property (@(posedge mclk) disable iff (rst)
    hit(`PIFB_OFS_FLAGS_C) && !src.c[`PIFB_BIT_CAPTURE5]
      && !wr_byte[`PIFB_BIT_CAPTURE5] |=> !flags_c[`PIFB_BIT_CAPTURE5])
    else $error("write zero did not clear");

  a_wait_one_cycle:
  assert property (@(posedge mclk) disable iff (rst)
    $fell(rsp_reg.waitrequest) |=> rsp_reg.waitrequest)
    else $error("waitrequest low too long");

  a_irq_follows:
  assert property (@(posedge mclk) disable iff (rst)
    irq == |(status & mask))
    else $error("irq not status and mask");

  a_answer_next_cycle:
  assert property (@(posedge mclk) disable iff (rst)
    (bus_req.read | bus_req.write) && rsp_reg.waitrequest |=> !rsp_reg.waitrequest)
    else $error("request not answered next cycle");

  a_d_unused_zero:
  assert property (@(posedge mclk) disable iff (rst)
    (flags_d & ~`PIFB_IMPL_D) == 8'h00)
    else $error("flags d unused bits not zero");

endmodule

/* bench/pifb_irq_bank_tb.sv */
`timescale 1ns/1ps
`include "pifb_consts.svh"

module pifb_irq_bank_tb;
  // ==========================================================
  // Signals
  logic                     mclk;
  logic                     rst;
  pifb_pkg::pifb_avmm_req_t breq;
  pifb_pkg::pifb_avmm_rsp_t brsp;
  pifb_pkg::pifb_bank_t     src;
  pifb_pkg::pifb_enables_t  en_ext;
  pifb_pkg::pifb_bank_t     req;
  logic                     service_req;
  logic                     irq;
  logic [31:0]              rd;
  int                       bad_count;
  int                       check_count;

  // ==========================================================
  // Device
  pifb_irq_bank dut (
    .mclk        (mclk),
    .rst         (rst),
    .bus_req     (breq),
    .bus_rsp     (brsp),
    .src         (src),
    .en_ext      (en_ext),
    .req         (req),
    .service_req (service_req),
    .irq         (irq)
  );

  // ==========================================================
  // Clock, 100 ns period
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;

  // ==========================================================
  // Tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict;
    $display("Mismatches %0d, comparisons %0d", bad_count, check_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low
  task bus_xfer(input logic wr, input logic [4:0] a, input logic [7:0] d,
                output logic [31:0] q);
    q = 32'h0000_0000;
    @(posedge mclk);
    breq.read       <= ~wr;
    breq.write      <= wr;
    breq.address    <= a;
    breq.writedata  <= {24'h00_0000, d};
    breq.byteenable <= 4'h1;
    do begin
      @(posedge mclk);
    end while (brsp.waitrequest !== 1'b0);
    q = brsp.readdata;
    breq.read  <= 1'b0;
    breq.write <= 1'b0;
  endtask

  task bus_write(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus_xfer(1'b1, a, d, q);
  endtask

  task bus_read(input logic [4:0] a, output logic [31:0] q);
    bus_xfer(1'b0, a, 8'h00, q);
  endtask

  task read_check(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_read(a, q);
    check(q, exp);
  endtask

  // One-cycle event pulse on the sources
  task pulse(input pifb_pkg::pifb_bank_t v);
    @(posedge mclk);
    src <= v;
    @(posedge mclk);
    src <= '0;
    repeat (3) @(posedge mclk);
  endtask

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Tests
  initial begin
    rst         = 1'b1;
    breq        = '0;
    src         = '0;
    en_ext      = '0;
    bad_count   = 0;
    check_count = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);

    // Reset values, unmapped word included
    for (int i = 0; i < 8; i++) begin
      read_check(5'(i * 4), 32'h0000_0000);
    end
    check({31'h0, service_req}, 32'h0000_0000);

    // Serial-2 enables, unimplemented bits read zero
    bus_write(`PIFB_OFS_SER2_EN, 8'hff);
    read_check(`PIFB_OFS_SER2_EN, 32'h0000_0033);
    bus_write(`PIFB_OFS_SER2_EN, 8'h00);
    read_check(`PIFB_OFS_SER2_EN, 32'h0000_0000);

    // Unmapped write ignored
    bus_write(5'h1c, 8'hff);
    read_check(5'h1c, 32'h0000_0000);

    // Events set flags with every enable off
    pulse('{a: 8'hff, b: 8'hff, c: 8'hff, d: 8'hff});
    read_check(`PIFB_OFS_FLAGS_A, 32'h0000_00cf);
    read_check(`PIFB_OFS_FLAGS_B, 32'h0000_00fd);
    read_check(`PIFB_OFS_FLAGS_C, 32'h0000_007a);
    read_check(`PIFB_OFS_FLAGS_D, 32'h0000_0033);
    check({31'h0, service_req}, 32'h0000_0000);
    check(32'(req), 32'h0000_0000);

    // Request only where flag and enable are both one
    @(posedge mclk);
    en_ext <= '{a: 8'h81, b: 8'h82, c: 8'h40};
    repeat (3) @(posedge mclk);
    check(32'(req), 32'h8180_4000);
    check({31'h0, service_req}, 32'h0000_0001);
    @(posedge mclk);
    en_ext <= '0;

    // Software clear; read-only uart1 bits untouched by writes
    bus_write(`PIFB_OFS_FLAGS_A, 8'h00);
    read_check(`PIFB_OFS_FLAGS_A, 32'h0000_0000);
    bus_write(`PIFB_OFS_FLAGS_A, 8'hff);
    read_check(`PIFB_OFS_FLAGS_A, 32'h0000_00cf);
    @(posedge mclk);
    src.a <= 8'h20;
    bus_write(`PIFB_OFS_FLAGS_A, 8'h00);
    read_check(`PIFB_OFS_FLAGS_A, 32'h0000_0020);
    @(posedge mclk);
    src.a <= 8'h00;
    repeat (2) @(posedge mclk);
    read_check(`PIFB_OFS_FLAGS_A, 32'h0000_0000);

    // Event held during a clearing write wins
    @(posedge mclk);
    src.b <= 8'h80;
    bus_write(`PIFB_OFS_FLAGS_B, 8'h00);
    @(posedge mclk);
    src.b <= 8'h00;
    read_check(`PIFB_OFS_FLAGS_B, 32'h0000_0080);
    bus_write(`PIFB_OFS_FLAGS_B, 8'h00);
    bus_write(`PIFB_OFS_FLAGS_C, 8'h00);
    read_check(`PIFB_OFS_FLAGS_C, 32'h0000_0000);

    // Serial-2 enable drives requests of flags d, cleared first
    bus_write(`PIFB_OFS_FLAGS_D, 8'h00);
    read_check(`PIFB_OFS_FLAGS_D, 32'h0000_0000);
    bus_write(`PIFB_OFS_SER2_EN, 8'h30);
    check(32'(req), 32'h0000_0000);
    pulse('{a: 8'h00, b: 8'h00, c: 8'h00, d: 8'h31});
    check(32'(req), 32'h0000_0030);
    check({31'h0, service_req}, 32'h0000_0001);
    bus_write(`PIFB_OFS_SER2_EN, 8'h00);
    bus_write(`PIFB_OFS_FLAGS_D, 8'h00);

    // Status, mask and interrupt line
    bus_read(`PIFB_OFS_STATUS, rd);
    read_check(`PIFB_OFS_STATUS, 32'h0000_0000);
    bus_write(`PIFB_OFS_MASK, 8'hff);
    read_check(`PIFB_OFS_MASK, 32'h0000_000f);
    check({31'h0, irq}, 32'h0000_0000);
    pulse('{a: 8'h00, b: 8'h00, c: 8'h40, d: 8'h00});
    check({31'h0, irq}, 32'h0000_0001);
    read_check(`PIFB_OFS_STATUS, 32'h0000_0004);
    repeat (2) @(posedge mclk);
    check({31'h0, irq}, 32'h0000_0000);
    read_check(`PIFB_OFS_STATUS, 32'h0000_0000);
    bus_write(`PIFB_OFS_MASK, 8'h0b);
    bus_write(`PIFB_OFS_FLAGS_C, 8'h00);
    pulse('{a: 8'h00, b: 8'h00, c: 8'h08, d: 8'h00});
    check({31'h0, irq}, 32'h0000_0000);
    read_check(`PIFB_OFS_STATUS, 32'h0000_0004);
    read_check(`PIFB_OFS_FLAGS_C, 32'h0000_0008);

    // Second reset clears everything again
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    read_check(`PIFB_OFS_FLAGS_C, 32'h0000_0000);
    read_check(`PIFB_OFS_MASK, 32'h0000_0000);
    print_verdict();
  end
endmodule
